// [core/fsb_host.sv]
// Purpose: host controller driving the flash side of a flash/SRAM stack
// Assumes: software orders single reads, writes and resets over Wishbone
// Notes: command sequences are built by software from single writes
// Function
// - Read: select and output enable low, write high
// - Write: write enable and select low, output high
// - Bypass programming needs two writes, not four
// - High voltage only during accelerated programming
`timescale 1ns/10ps
module fsb_host (
   input wire logic clk, // 20 MHz clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   input wire logic wb_we_i, // Wishbone write
   input wire logic [4:0] wb_adr_i, // Wishbone byte address
   input wire logic [3:0] wb_sel_i, // Wishbone byte enables
   input wire logic [31:0] wb_dat_i, // Wishbone write data
   output logic [31:0] wb_dat_o, // Wishbone read data
   output logic wb_ack_o, // Wishbone acknowledge
   output logic flash_select_n, // Flash chip select
   output logic flash_read_en_n, // Flash output enable
   output logic flash_write_en_n, // Flash write enable
   output logic flash_reset_n, // Flash hardware reset
   output logic [19:0] flash_addr, // Flash word address
   output logic flash_width_select, // 1 word, 0 byte
   output logic protect_level, // Protect pin logic level
   output logic accel_voltage_level, // Request high voltage on protect pin
   output logic [15:0] dq_o, // Data pins out
   output logic [15:0] dq_oe_n, // Data pin enables, low drives
   input wire logic [15:0] dq_i, // Data pins in
   output logic sram_select1_n, // SRAM select, held off
   output logic sram_select2, // SRAM select, held off
   output logic sram_low_byte_n, // SRAM low byte lane
   output logic sram_high_byte_n, // SRAM high byte lane
   output logic sram_width_select // SRAM width
);
   fsb_pkg::fsb_state_t state_ff;
   logic [5:0] ctrl_ff;
   logic [20:0] addr_ff;
   logic [15:0] wdata_ff;
   logic [15:0] rdata_ff;
   logic done_ff;
   logic [7:0] cnt_ff;
   logic [1:0] op_ff;
   logic [15:0] s1_ff;
   logic [15:0] s2_ff;
   logic [15:0] s3_ff;
   logic bus_req;
   logic wr_req;
   logic busy;
   logic go;

   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_req = bus_req & wb_we_i;
   assign busy = (state_ff != fsb_pkg::ST_IDLE);
   // A start while busy is dropped rather than corrupting the cycle
   assign go = wr_req && wb_adr_i == fsb_pkg::REG_CTRL && wb_sel_i[0] && wb_dat_i[fsb_pkg::CTRL_GO] && !busy;

   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : lane_merge

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= bus_req;
         case (wb_adr_i)
            fsb_pkg::REG_CTRL: wb_dat_o <= {26'h000_0000, ctrl_ff};
            fsb_pkg::REG_ADDR: wb_dat_o <= {11'h000, addr_ff};
            fsb_pkg::REG_WDATA: wb_dat_o <= {16'h0000, wdata_ff};
            fsb_pkg::REG_RDATA: wb_dat_o <= {16'h0000, rdata_ff};
            fsb_pkg::REG_STATUS: wb_dat_o <= {30'h0000_0000, done_ff, busy};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // Control bits may change only while idle so pins stay stable in a cycle
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ctrl_ff <= fsb_pkg::CTRL_RST;
         addr_ff <= 21'h00_0000;
         wdata_ff <= 16'h0000;
      end
      else if (wr_req && !busy)
      begin
         case (wb_adr_i)
            fsb_pkg::REG_CTRL: ctrl_ff <= 6'(lane_merge({26'h000_0000, ctrl_ff}, wb_dat_i, wb_sel_i)) & 6'h3E;
            fsb_pkg::REG_ADDR: addr_ff <= 21'(lane_merge({11'h000, addr_ff}, wb_dat_i, wb_sel_i));
            fsb_pkg::REG_WDATA: wdata_ff <= 16'(lane_merge({16'h0000, wdata_ff}, wb_dat_i, wb_sel_i));
            default: ;
         endcase
      end
   end

   // Three-stage input sampling of the asynchronous data pins
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         s1_ff <= 16'h0000;
         s2_ff <= 16'h0000;
         s3_ff <= 16'h0000;
      end
      else
      begin
         s1_ff <= dq_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         state_ff <= fsb_pkg::ST_IDLE;
         cnt_ff <= 8'h00;
         op_ff <= fsb_pkg::OP_READ;
         done_ff <= 1'b0;
         rdata_ff <= 16'h0000;
      end
      else
      begin
         case (state_ff)
            fsb_pkg::ST_IDLE:
            begin
               if (go)
               begin
                  op_ff <= wb_dat_i[fsb_pkg::CTRL_OP_LO +: 2];
                  done_ff <= 1'b0;
                  cnt_ff <= fsb_pkg::CNT_RST;
                  if (wb_dat_i[fsb_pkg::CTRL_OP_LO +: 2] == fsb_pkg::OP_RESET)
                  begin
                     state_ff <= fsb_pkg::ST_RESET;
                  end
                  else if (wb_dat_i[fsb_pkg::CTRL_OP_LO +: 2] == fsb_pkg::OP_READ
                     || wb_dat_i[fsb_pkg::CTRL_OP_LO +: 2] == fsb_pkg::OP_WRITE)
                  begin
                     state_ff <= fsb_pkg::ST_SETUP;
                  end
                  else
                  begin
                     done_ff <= 1'b1;
                  end
               end
            end
            fsb_pkg::ST_SETUP:
            begin
               state_ff <= fsb_pkg::ST_STROBE;
               cnt_ff <= (op_ff == fsb_pkg::OP_READ) ? fsb_pkg::CNT_ACC : fsb_pkg::CNT_WE;
            end
            fsb_pkg::ST_STROBE:
            begin
               if (cnt_ff > 8'h01)
               begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
               else if (op_ff != fsb_pkg::OP_READ || s2_ff == s3_ff)
               begin
                  state_ff <= fsb_pkg::ST_HOLD;
                  if (op_ff == fsb_pkg::OP_READ)
                  begin
                     rdata_ff <= ctrl_ff[fsb_pkg::CTRL_WORD] ? s3_ff : {8'h00, s3_ff[7:0]};
                  end
               end
            end
            fsb_pkg::ST_HOLD:
            begin
               state_ff <= fsb_pkg::ST_IDLE;
               done_ff <= 1'b1;
            end
            fsb_pkg::ST_RESET:
            begin
               if (cnt_ff > 8'h01)
               begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
               else if (flash_reset_n)
               begin
                  state_ff <= fsb_pkg::ST_IDLE;
                  done_ff <= 1'b1;
               end
               else
               begin
                  cnt_ff <= fsb_pkg::CNT_RCV;
               end
            end
            default:
            begin
               state_ff <= fsb_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Pin drivers; pins are registered from the current state so strobes never glitch
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         flash_select_n <= 1'b1;
         flash_read_en_n <= 1'b1;
         flash_write_en_n <= 1'b1;
         flash_reset_n <= 1'b0;
         flash_addr <= 20'h0_0000;
         flash_width_select <= 1'b1;
         protect_level <= 1'b0;
         accel_voltage_level <= 1'b0;
         dq_o <= 16'h0000;
         dq_oe_n <= 16'hFFFF;
      end
      else
      begin
         flash_width_select <= ctrl_ff[fsb_pkg::CTRL_WORD];
         protect_level <= ctrl_ff[fsb_pkg::CTRL_WP_HIGH];
         // High voltage only around an accelerated program write
         accel_voltage_level <= ctrl_ff[fsb_pkg::CTRL_ACCEL] && busy && op_ff == fsb_pkg::OP_WRITE
            && state_ff != fsb_pkg::ST_HOLD;
         flash_reset_n <= !(state_ff == fsb_pkg::ST_RESET && cnt_ff > 8'h01 && !flash_reset_n)
            && !(go && wb_dat_i[fsb_pkg::CTRL_OP_LO +: 2] == fsb_pkg::OP_RESET);
         flash_addr <= ctrl_ff[fsb_pkg::CTRL_WORD] ? addr_ff[19:0] : addr_ff[20:1];
         flash_select_n <= !(state_ff == fsb_pkg::ST_SETUP || state_ff == fsb_pkg::ST_STROBE);
         flash_read_en_n <= !(state_ff == fsb_pkg::ST_SETUP && op_ff == fsb_pkg::OP_READ
            || state_ff == fsb_pkg::ST_STROBE && op_ff == fsb_pkg::OP_READ
            && !(cnt_ff <= 8'h01 && s2_ff == s3_ff));
         flash_write_en_n <= !(state_ff == fsb_pkg::ST_SETUP && op_ff == fsb_pkg::OP_WRITE
            || state_ff == fsb_pkg::ST_STROBE && op_ff == fsb_pkg::OP_WRITE && cnt_ff > 8'h01);
         dq_o <= ctrl_ff[fsb_pkg::CTRL_WORD] ? wdata_ff : {addr_ff[0], 7'h00, wdata_ff[7:0]};
         // Host drives data only while the flash outputs are off, except pin fifteen (low address bit) during byte-mode reads
         if (state_ff == fsb_pkg::ST_SETUP && op_ff == fsb_pkg::OP_WRITE
            || state_ff == fsb_pkg::ST_STROBE && op_ff == fsb_pkg::OP_WRITE
            || state_ff == fsb_pkg::ST_HOLD && op_ff == fsb_pkg::OP_WRITE)
         begin
            dq_oe_n <= ctrl_ff[fsb_pkg::CTRL_WORD] ? 16'h0000 : 16'h7F00;
         end
         else if (!ctrl_ff[fsb_pkg::CTRL_WORD] && (state_ff == fsb_pkg::ST_SETUP || state_ff == fsb_pkg::ST_STROBE))
         begin
            dq_oe_n <= 16'h7FFF;
         end
         else
         begin
            dq_oe_n <= 16'hFFFF;
         end
      end
   end

   // SRAM is never used by this host, so it stays deselected
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         sram_select1_n <= 1'b1;
         sram_select2 <= 1'b0;
         sram_low_byte_n <= 1'b1;
         sram_high_byte_n <= 1'b1;
         sram_width_select <= 1'b1;
      end
      else
      begin
         sram_select1_n <= 1'b1;
         sram_select2 <= 1'b0;
         sram_low_byte_n <= 1'b1;
         sram_high_byte_n <= 1'b1;
         sram_width_select <= 1'b1;
      end
   end
endmodule : fsb_host

// [common/fsb_pkg.sv]
// Purpose: constants for the flash bus host controller
// Assumes: 20 MHz clock, 32-bit classic Wishbone register port
// Notes: none
package fsb_pkg;
   localparam int CLK_NS = 50;
   localparam int ACCESS_NS = 85;
   localparam int WE_PULSE_NS = 50;
   localparam int RESET_PULSE_NS = 500;
   localparam int RESET_RECOVER_NS = 100;
   localparam int ACC_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int WE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RST_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int RCV_CYC = (RESET_RECOVER_NS + CLK_NS - 1) / CLK_NS;
   localparam int SYNC_CYC = 3;
   localparam logic [7:0] CNT_ACC = 8'(ACC_CYC + SYNC_CYC);
   localparam logic [7:0] CNT_WE = 8'(WE_CYC);
   localparam logic [7:0] CNT_RST = 8'(RST_CYC);
   localparam logic [7:0] CNT_RCV = 8'(RCV_CYC);
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_ADDR = 5'h04;
   localparam logic [4:0] REG_WDATA = 5'h08;
   localparam logic [4:0] REG_RDATA = 5'h0C;
   localparam logic [4:0] REG_STATUS = 5'h10;
   localparam int CTRL_GO = 0;
   localparam int CTRL_OP_LO = 1;
   localparam int CTRL_WORD = 3;
   localparam int CTRL_WP_HIGH = 4;
   localparam int CTRL_ACCEL = 5;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_RESET = 2'h2;
   localparam logic [5:0] CTRL_RST = 6'h08;
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_SETUP = 5'b00010,
      ST_STROBE = 5'b00100,
      ST_HOLD = 5'b01000,
      ST_RESET = 5'b10000
   } fsb_state_t;
endpackage : fsb_pkg

// [bench/fsb_host_chk.sv]
// Purpose: port assertions for the flash bus host
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every host instance
`timescale 1ns/10ps
module fsb_host_chk (
   input wire logic clk, // Clock
   input wire logic rstn, // Reset
   input wire logic wb_cyc_i, // Cycle
   input wire logic wb_stb_i, // Strobe
   input wire logic wb_ack_o, // Ack
   input wire logic flash_select_n, // Select
   input wire logic flash_read_en_n, // Output enable
   input wire logic flash_write_en_n, // Write enable
   input wire logic flash_reset_n, // Flash reset
   input wire logic flash_width_select, // Width
   input wire logic accel_voltage_level, // High voltage
   input wire logic [15:0] dq_oe_n, // Data enables
   input wire logic sram_select1_n, // SRAM select
   input wire logic sram_select2 // SRAM select
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   AST_RD: assert property (!flash_read_en_n |-> !flash_select_n && flash_write_en_n)
      else $error("read strobes wrong");
   AST_WR: assert property (!flash_write_en_n |-> !flash_select_n && flash_read_en_n)
      else $error("write strobes wrong");
   // Pin fifteen is an address input in byte mode, so the host may drive it during reads
   AST_BUS_FREE: assert property ((dq_oe_n[14:0] != 15'h7FFF || flash_width_select && !dq_oe_n[15])
      |-> flash_read_en_n)
      else $error("host drives during read");
   AST_BYTE_LSB: assert property (!flash_width_select && !flash_select_n |-> !dq_oe_n[15])
      else $error("low address bit not driven");
   AST_ACCEL: assert property (accel_voltage_level |-> flash_read_en_n && !flash_select_n)
      else $error("high voltage outside programming");
   AST_SRAM: assert property (sram_select1_n && !sram_select2)
      else $error("static RAM selected");
   AST_RST_LEN: assert property ($fell(flash_reset_n) |=> !flash_reset_n [*8])
      else $error("reset pulse short");
   AST_RST_IDLE: assert property (!flash_reset_n |-> flash_select_n && flash_write_en_n)
      else $error("access during reset");
   AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not one cycle");
   cover property ($fell(flash_read_en_n));
   cover property ($fell(flash_write_en_n) && !flash_width_select);
   cover property ($fell(flash_reset_n));
endmodule : fsb_host_chk

bind fsb_host fsb_host_chk u_chk (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .flash_select_n(flash_select_n), .flash_read_en_n(flash_read_en_n),
   .flash_write_en_n(flash_write_en_n), .flash_reset_n(flash_reset_n), .flash_width_select(flash_width_select),
   .accel_voltage_level(accel_voltage_level), .dq_oe_n(dq_oe_n), .sram_select1_n(sram_select1_n),
   .sram_select2(sram_select2));

// [bench/fsb_flash_model.sv]
// Purpose: behavioural flash device behind the host
// Assumes: small array, no unlock checking
// Notes: released pins show the inverse of the last value
`timescale 1ns/10ps
module fsb_flash_model #(
   parameter int ACC_NS = 85, // Read access delay
   parameter logic [7:0] ID_CODE = 8'h5A // Arbitrary value
) (
   input wire logic ce_n, // Select
   input wire logic oe_n, // Output enable
   input wire logic we_n, // Write enable
   input wire logic rst_n, // Hardware reset
   input wire logic word, // Width select
   input wire logic accel, // High voltage
   input wire logic [19:0] addr, // Word address
   input wire logic [15:0] dq, // Resolved pins
   output logic [15:0] q // Device side of pins
);
   logic [15:0] mem [256];
   logic [15:0] rd;
   logic [15:0] last = 16'h0000;
   logic bypass = 1'b0, auto = 1'b0, armed = 1'b0;
   wire drv = !ce_n && !oe_n && we_n && rst_n;
   initial for (int i = 0; i < 256; i++) mem[i] = 16'hC300 ^ 16'(i);
   always @(negedge rst_n) {bypass, auto, armed} = 3'h0;
   always @(posedge we_n)
      if (!ce_n && oe_n && rst_n)
      begin
         if (armed) mem[addr[7:0]] = dq;
         armed = (dq[7:0] == 8'hA0) && (bypass || accel);
         if (dq[7:0] == 8'h20) bypass = 1'b1;
         if (dq[7:0] == 8'h90) auto = 1'b1;
         if (dq[7:0] == 8'hF0) {bypass, auto} = 2'h0;
      end
   always @(posedge oe_n) last = q;
   // Byte mode: top pin is the low address bit
   assign rd = auto ? {8'h00, ID_CODE} : word ? mem[addr[7:0]] :
      {~last[15:8], dq[15] ? mem[addr[7:0]][15:8] : mem[addr[7:0]][7:0]};
   assign #(ACC_NS) q = drv ? rd : ~last;
endmodule : fsb_flash_model

// [bench/test_fsb_host.sv]
// Purpose: self-checking bench for the flash bus host
// Assumes: device model on the pins, bench as Wishbone master
// Notes: table rows first, reset and mode cases by hand
`timescale 1ns/10ps
module test_fsb_host;
   typedef struct {logic [1:0] op; logic wd; logic [20:0] a; logic [15:0] d; logic [15:0] e;} fsb_row_t;
   logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [3:0] sel = 4'hF;
   logic [31:0] dat = 32'h0, wb_dat_o, s;
   logic wb_ack_o, ce_n, oe_n, we_n, frst_n, width, accel, wp, s1n, s2p;
   logic [19:0] faddr;
   logic [15:0] dq_o, dq_oe_n, dq_i, mq, r;
   int miscompares = 0, checks = 0;
   fsb_row_t rows [11] = '{'{2'h0, 1'b1, 21'h10, 16'h0, 16'hC310}, '{2'h1, 1'b1, 21'h555, 16'h20, 16'h0},
      '{2'h1, 1'b1, 21'h555, 16'hA0, 16'h0}, '{2'h1, 1'b1, 21'h10, 16'h1234, 16'h0},
      '{2'h0, 1'b1, 21'h10, 16'h0, 16'h1234}, '{2'h1, 1'b1, 21'h555, 16'hF0, 16'h0},
      '{2'h1, 1'b1, 21'h555, 16'h90, 16'h0}, '{2'h0, 1'b1, 21'h0, 16'h0, 16'h005A},
      '{2'h1, 1'b1, 21'h0, 16'hF0, 16'h0}, '{2'h0, 1'b0, 21'h21, 16'h0, 16'h0012},
      '{2'h0, 1'b0, 21'h20, 16'h0, 16'h0034}};
   assign dq_i = (dq_o & ~dq_oe_n) | (mq & dq_oe_n);
   fsb_host u_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_select_n(ce_n),
      .flash_read_en_n(oe_n), .flash_write_en_n(we_n), .flash_reset_n(frst_n), .flash_addr(faddr),
      .flash_width_select(width), .protect_level(wp), .accel_voltage_level(accel), .dq_o(dq_o),
      .dq_oe_n(dq_oe_n), .dq_i(dq_i), .sram_select1_n(s1n), .sram_select2(s2p), .sram_low_byte_n(),
      .sram_high_byte_n(), .sram_width_select());
   fsb_flash_model u_mem (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .rst_n(frst_n), .word(width),
      .accel(accel), .addr(faddr), .dq(dq_i), .q(mq));
   initial
   begin
      forever #25 clk = ~clk;
   end
   task automatic end_of_test;
      $display("checks %0d, miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : check
   task automatic wb_cycle(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20)
      begin
         miscompares++;
         end_of_test();
      end
   endtask : wb_cycle
   task automatic flash_op(input logic [1:0] op, input logic wd, input logic ac, input logic [20:0] a,
      input logic [15:0] d, output logic [15:0] q);
      logic [31:0] t;
      int n;
      wb_cycle(1'b1, fsb_pkg::REG_ADDR, {11'h0, a}, t);
      wb_cycle(1'b1, fsb_pkg::REG_WDATA, {16'h0, d}, t);
      wb_cycle(1'b1, fsb_pkg::REG_CTRL, {26'h0, ac, 1'b1, wd, op, 1'b1}, t);
      n = 0;
      do
      begin
         wb_cycle(1'b0, fsb_pkg::REG_STATUS, 32'h0, t);
         n++;
      end
      while (t[1:0] !== 2'b10 && n < 50);
      if (n >= 50)
      begin
         miscompares++;
         end_of_test();
      end
      wb_cycle(1'b0, fsb_pkg::REG_RDATA, 32'h0, t);
      q = t[15:0];
   endtask : flash_op
   initial
   begin
      repeat (16) @(posedge clk);
      check("flash reset in reset", 32'h0, {31'h0, frst_n});
      check("pins in reset", 32'h2, {29'h0, wp, s1n, s2p});
      rstn <= 1'b1;
      foreach (rows[i])
      begin
         flash_op(rows[i].op, rows[i].wd, 1'b0, rows[i].a, rows[i].d, r);
         if (rows[i].op == fsb_pkg::OP_READ)
            check("row read", {16'h0, rows[i].e}, {16'h0, r});
         $display("row %0d done", i);
      end
      check("protect level high", 32'h6, {29'h0, wp, s1n, s2p});
      flash_op(fsb_pkg::OP_WRITE, 1'b1, 1'b0, 21'h555, 16'h0090, r);
      flash_op(fsb_pkg::OP_RESET, 1'b1, 1'b0, 21'h0, 16'h0, r);
      flash_op(fsb_pkg::OP_READ, 1'b1, 1'b0, 21'h10, 16'h0, r);
      check("read after flash reset", 32'h1234, {16'h0, r});
      $display("flash reset test done");
      // No bypass command here: the high voltage alone must arm programming
      flash_op(fsb_pkg::OP_WRITE, 1'b1, 1'b1, 21'h555, 16'h00A0, r);
      flash_op(fsb_pkg::OP_WRITE, 1'b1, 1'b1, 21'h11, 16'h5678, r);
      flash_op(fsb_pkg::OP_READ, 1'b1, 1'b0, 21'h11, 16'h0, r);
      check("accelerated program", 32'h5678, {16'h0, r});
      $display("accelerated program test done");
      flash_op(2'h3, 1'b1, 1'b0, 21'h11, 16'hFFFF, r);
      check("no-op leaves read data", 32'h5678, {16'h0, r});
      wb_cycle(1'b1, fsb_pkg::REG_CTRL, 32'h19, s);
      wb_cycle(1'b1, fsb_pkg::REG_ADDR, 32'h33, s);
      wb_cycle(1'b0, fsb_pkg::REG_ADDR, 32'h0, s);
      check("address write while busy", 32'h11, s);
      repeat (12) @(posedge clk);
      wb_cycle(1'b0, fsb_pkg::REG_RDATA, 32'h0, s);
      check("read behind refused write", 32'h5678, s);
      $display("refused cases test done");
      wb_cycle(1'b0, 5'h14, 32'h0, s);
      check("unmapped read", 32'h0, s);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      check("mid-run reset", 32'h1, {30'h0, frst_n, ce_n});
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      check("flash reset released", 32'h1, {31'h0, frst_n});
      wb_cycle(1'b0, fsb_pkg::REG_STATUS, 32'h0, s);
      check("status after reset", 32'h0, s);
      $display("reset test done");
      end_of_test();
   end
endmodule : test_fsb_host
